// ==== initiator_model.sv ====
`timescale 1ns/10ps
module initiator_model (
   // register bus toward the engine
   input  wire logic        ref_clk_i,
   input  wire logic [31:0] rdata_i,
   output logic      [7:0]  addr_o,
   output logic      [31:0] wdata_o,
   output logic             wr_o,
   output logic             rd_o
);
   initial begin
      addr_o = 8'h00;
      wdata_o = 32'h0000_0000;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // header word carries code, control byte and length
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge ref_clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge ref_clk_i);
      rd_o <= 1'b0;
      #1;
      d = rdata_i;
   endtask : rd
endmodule : initiator_model

// ==== log_engine.sv ====
`timescale 1ns/10ps
module log_engine #(
   parameter logic [log_engine_pkg::CNT_W-1:0] CNT_MAX =
      log_engine_pkg::CNT_MAX_DEF,
   parameter int AUTOSAVE_CYCLES = log_engine_pkg::AUTOSAVE_CYC
) (
   // clock and reset
   input  wire logic                              ref_clk_i,
   input  wire logic                              arst_n_i,
   // register port
   input  wire logic [log_engine_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [31:0]                       wdata_i,
   input  wire logic                              wr_i,
   input  wire logic                              rd_i,
   output logic      [31:0]                       rdata_o,
   // counted events
   input  wire logic [log_engine_pkg::N_CNT-1:0]  cnt_event_i,
   // list events
   input  wire logic                              list_event_i,
   input  wire logic [31:0]                       list_text_i,
   // command result
   output logic                                   cmd_done_o,
   output log_engine_pkg::cmd_status_t            cmd_status_o,
   output logic                                   unit_attention_o
);
   localparam int N_CNT  = log_engine_pkg::N_CNT;
   localparam int N_LIST = log_engine_pkg::N_LIST;
   localparam int CNT_W  = log_engine_pkg::CNT_W;

   logic [CNT_W-1:0] ctr [N_CNT], thr [N_CNT], saved [N_CNT], nxt [N_CNT];
   log_engine_pkg::ctrl_byte_t        cctl     [N_CNT];
   logic [N_CNT-1:0]                  cnt_inc;
   logic [N_CNT-1:0]                  cmp_true;
   logic [N_CNT-1:0]                  cmp_hit;
   logic [31:0]                       list_txt [N_LIST];
   logic [log_engine_pkg::LIDX_W-1:0] list_next;
   log_engine_pkg::param_hdr_t        hdr;
   logic [31:0]                       val;
   log_engine_pkg::param_hdr_t        s_hdr;
   logic [31:0]                       s_val;
   log_engine_pkg::page_kind_t        kind;
   log_engine_pkg::page_kind_t        last_kind;
   log_engine_pkg::cmd_status_t       next_status;
   log_engine_pkg::cmd_word_t         cmd;
   logic [CNT_W-1:0]                  new_val;
   logic [log_engine_pkg::CIDX_W-1:0] hidx;
   logic [31:0]                       tick_cnt;
   logic [log_engine_pkg::ADDR_W-3:0] word;
   logic hit_max, frozen, list_wrapped, list_take, report_log_exception, cmd_go, pc_cum;
   logic on_cnt, on_list, code_ok, bad_cnt, bad_list, bad_field, cmd_ok;
   logic sel_cnt, sel_list, save_go, tick, ua_clr;

   function automatic logic printable(input logic [31:0] t);
      logic ok;
      ok = 1'b1;
      for (int b = 0; b < 4; b++) begin
         if (t[8*b +: 8] < log_engine_pkg::ASCII_LO ||
             t[8*b +: 8] > log_engine_pkg::ASCII_HI) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction : printable

   function automatic log_engine_pkg::page_kind_t page_kind(
      input logic [5:0] pc);
      if (pc >= log_engine_pkg::PG_VEND_LO &&
          pc <= log_engine_pkg::PG_VEND_HI) begin
         return log_engine_pkg::PK_VENDOR;
      end
      if (pc >= log_engine_pkg::PG_RSV_LO) begin
         return log_engine_pkg::PK_RESERVED;
      end
      unique case (pc)
         log_engine_pkg::PG_WRITE:  return log_engine_pkg::PK_WRITE;
         log_engine_pkg::PG_READ:   return log_engine_pkg::PK_READ;
         log_engine_pkg::PG_RREV:   return log_engine_pkg::PK_RREV;
         log_engine_pkg::PG_VERIFY: return log_engine_pkg::PK_VERIFY;
         log_engine_pkg::PG_NONMED: return log_engine_pkg::PK_NONMED;
         log_engine_pkg::PG_LASTEV: return log_engine_pkg::PK_LASTEV;
         6'h00:                     return log_engine_pkg::PK_SUPPORTED;
         default:                   return log_engine_pkg::PK_OTHER;
      endcase
   endfunction : page_kind

   // counter update and threshold compare
   always_comb begin
      hit_max = 1'b0;
      for (int i = 0; i < N_CNT; i++) begin
         nxt[i] = ctr[i] + log_engine_pkg::CNT_ONE;
         cnt_inc[i] = cnt_event_i[i] && !cctl[i].du && !frozen &&
                      ctr[i] != CNT_MAX;
         unique case (cctl[i].threshold_criteria)
            log_engine_pkg::TMC_EVERY: cmp_true[i] = 1'b1;
            log_engine_pkg::TMC_EQ:    cmp_true[i] = nxt[i] == thr[i];
            log_engine_pkg::TMC_NE:    cmp_true[i] = nxt[i] != thr[i];
            log_engine_pkg::TMC_GT:    cmp_true[i] = nxt[i] > thr[i];
         endcase
         cmp_hit[i] = cnt_inc[i] && cctl[i].etc && cmp_true[i];
         if (cnt_inc[i] && nxt[i] == CNT_MAX) begin
            hit_max = 1'b1;
         end
      end
   end

   // command decode and header checks
   assign cmd     = log_engine_pkg::cmd_word_t'(wdata_i);
   assign cmd_go  = wr_i && addr_i == log_engine_pkg::OFS_CMD;
   assign pc_cum  = cmd.page_control[log_engine_pkg::PC_CUM_BIT];
   assign kind    = page_kind(cmd.page_code);
   assign on_cnt  = cmd.page_code == log_engine_pkg::CNT_PAGE;
   assign on_list = cmd.page_code == log_engine_pkg::LIST_PAGE;
   assign hidx    = hdr.code[log_engine_pkg::CIDX_W-1:0];
   assign new_val = val[CNT_W-1:0];
   assign code_ok = on_cnt ? hdr.code < 16'(N_CNT) : hdr.code < 16'(N_LIST);
   assign bad_cnt = hdr.ctrl.lp ||
                    hdr.len < log_engine_pkg::CNT_BYTES ||
                    val[31:CNT_W] != 16'h0000 || new_val > CNT_MAX;
   assign bad_list = !hdr.ctrl.lp ||
                     hdr.ctrl.etc || hdr.ctrl.threshold_criteria != 2'h0 ||
                     hdr.len < log_engine_pkg::LIST_BYTES ||
                     !printable(val);
   assign bad_field = !code_ok ||
                      (cmd.select && (on_cnt ? bad_cnt : bad_list));
   assign cmd_ok   = (on_cnt || on_list) && !bad_field;
   assign sel_cnt  = cmd_go && cmd.select && on_cnt && cmd_ok;
   assign sel_list = cmd_go && cmd.select && on_list && cmd_ok;
   assign save_go  = cmd_go && cmd.save_parameters && on_cnt && cmd_ok;

   always_comb begin
      if (!(on_cnt || on_list)) begin
         next_status = log_engine_pkg::ST_BAD_PAGE;
      end else if (bad_field) begin
         next_status = log_engine_pkg::ST_BAD_FIELD;
      end else if (report_log_exception && on_cnt && frozen) begin
         next_status = log_engine_pkg::ST_CTR_MAX;
      end else if (report_log_exception && on_list && list_wrapped) begin
         next_status = log_engine_pkg::ST_LIST_EXH;
      end else begin
         next_status = log_engine_pkg::ST_GOOD;
      end
   end

   // counters, thresholds and control bytes
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < N_CNT; i++) begin
            ctr[i]  <= '0;
            thr[i]  <= '0;
            cctl[i] <= '0;
         end
      end else begin
         for (int i = 0; i < N_CNT; i++) begin
            if (sel_cnt && hidx == i) begin
               if (pc_cum) begin
                  ctr[i] <= new_val;
               end else begin
                  thr[i] <= new_val;
               end
               cctl[i].ds   <= hdr.ctrl.ds;
               cctl[i].target_save_disable  <= hdr.ctrl.target_save_disable;
               cctl[i].etc  <= hdr.ctrl.etc;
               cctl[i].threshold_criteria  <= hdr.ctrl.threshold_criteria;
               cctl[i].du   <= pc_cum ? new_val == CNT_MAX
                                      : cctl[i].du;
            end else if (cnt_inc[i]) begin
               ctr[i] <= nxt[i];
               if (nxt[i] == CNT_MAX) begin
                  cctl[i].du <= 1'b1;
               end
            end
         end
      end
   end

   // page freeze once any counter saturates
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         frozen <= 1'b0;
      end else begin
         frozen <= (frozen && !sel_cnt) || hit_max ||
                   (sel_cnt && pc_cum && new_val == CNT_MAX);
      end
   end

   // implicit save tick
   assign tick = tick_cnt == 32'(AUTOSAVE_CYCLES - 1);
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick ? '0 : tick_cnt + 32'h0000_0001;
      end
   end

   // saved copies
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < N_CNT; i++) begin
            saved[i] <= '0;
         end
      end else begin
         for (int i = 0; i < N_CNT; i++) begin
            if (save_go && !cctl[i].ds) begin
               saved[i] <= pc_cum ? ctr[i] : thr[i];
            end else if (tick && !cctl[i].target_save_disable) begin
               saved[i] <= ctr[i];
            end
         end
      end
   end

   // unit attention, set wins over clear
   assign ua_clr = wr_i && addr_i == log_engine_pkg::OFS_STATUS &&
                   wdata_i[log_engine_pkg::ST_UA_BIT];
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         unit_attention_o <= 1'b0;
      end else begin
         unit_attention_o <= (unit_attention_o && !ua_clr) ||
                             |cmp_hit;
      end
   end

   // list parameters with wrapping codes
   assign list_take = list_event_i && printable(list_text_i);
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         list_next <= '0;
         for (int j = 0; j < N_LIST; j++) begin
            list_txt[j] <= '0;
         end
      end else begin
         for (int j = 0; j < N_LIST; j++) begin
            if (sel_list && hdr.code == 16'(j)) begin
               list_txt[j] <= val;
            end else if (list_take && list_next == j) begin
               list_txt[j] <= list_text_i;
            end
         end
         if (list_take) begin
            list_next <= list_next + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         list_wrapped <= 1'b0;
      end else begin
         list_wrapped <= (list_wrapped && !(cmd_go && on_list && cmd_ok)) ||
                         (list_take && list_next == 2'(N_LIST - 1));
      end
   end

   // software registers
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         report_log_exception <= log_engine_pkg::CONFIG_RST[log_engine_pkg::CFG_RLE_BIT];
         hdr  <= '0;
         val  <= '0;
      end else if (wr_i) begin
         if (addr_i == log_engine_pkg::OFS_CONFIG) begin
            report_log_exception <= wdata_i[log_engine_pkg::CFG_RLE_BIT];
         end
         if (addr_i == log_engine_pkg::OFS_HDR) begin
            hdr <= log_engine_pkg::param_hdr_t'(wdata_i);
         end
         if (addr_i == log_engine_pkg::OFS_VALUE) begin
            val <= wdata_i;
         end
      end
   end

   // command result and sense data
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cmd_done_o   <= 1'b0;
         cmd_status_o <= log_engine_pkg::ST_GOOD;
         last_kind    <= log_engine_pkg::PK_SUPPORTED;
         s_hdr        <= '0;
         s_val        <= '0;
      end else begin
         cmd_done_o <= cmd_go;
         if (cmd_go) begin
            cmd_status_o    <= next_status;
            last_kind       <= kind;
            s_hdr           <= '0;
            s_val           <= '0;
            if (cmd_ok && !cmd.select && on_cnt) begin
               s_hdr.code   <= hdr.code;
               s_hdr.ctrl   <= cctl[hidx];
               s_hdr.len    <= log_engine_pkg::CNT_BYTES;
               s_val        <= 32'(pc_cum ? ctr[hidx] : thr[hidx]);
            end else if (cmd_ok && !cmd.select) begin
               s_hdr.code     <= hdr.code;
               s_hdr.ctrl.lp  <= 1'b1;
               s_hdr.ctrl.ds  <= 1'b1;
               s_hdr.ctrl.target_save_disable <= 1'b1;
               s_hdr.len      <= log_engine_pkg::LIST_BYTES;
               s_val <= list_txt[hdr.code[log_engine_pkg::LIDX_W-1:0]];
            end
         end
      end
   end

   // read port, data in the cycle after the strobe only
   assign word = addr_i[log_engine_pkg::ADDR_W-1:2];
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= '0;
         if (rd_i) begin
            unique case (addr_i)
               log_engine_pkg::OFS_CONFIG: rdata_o <= 32'(report_log_exception);
               log_engine_pkg::OFS_HDR:    rdata_o <= hdr;
               log_engine_pkg::OFS_VALUE:  rdata_o <= val;
               log_engine_pkg::OFS_STATUS: begin
                  rdata_o[2:0] <= cmd_status_o;
                  rdata_o[log_engine_pkg::ST_UA_BIT]     <= unit_attention_o;
                  rdata_o[log_engine_pkg::ST_FROZEN_BIT] <= frozen;
                  rdata_o[log_engine_pkg::ST_WRAP_BIT]   <= list_wrapped;
               end
               log_engine_pkg::OFS_S_HDR:  rdata_o <= s_hdr;
               log_engine_pkg::OFS_S_VAL:  rdata_o <= s_val;
               log_engine_pkg::OFS_KIND:   rdata_o <= 32'(last_kind);
               default: begin
                  for (int i = 0; i < N_CNT; i++) begin
                     if (word == 6'(i) + log_engine_pkg::OFS_SAVED[7:2]) begin
                        rdata_o <= 32'(saved[i]);
                     end
                  end
                  for (int j = 0; j < N_LIST; j++) begin
                     if (word == 6'(j) + log_engine_pkg::OFS_LIST[7:2]) begin
                        rdata_o <= list_txt[j];
                     end
                  end
               end
            endcase
         end
      end
   end

   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);

   chk_cnt_step: assert property (
      cnt_inc[1] && !(sel_cnt && hidx == 2'h1) |=>
      ctr[1] == $past(ctr[1]) + log_engine_pkg::CNT_ONE)
      else $error("counter did not step on event");
   chk_du_hold: assert property (
      cctl[1].du && !sel_cnt |=> ctr[1] == $past(ctr[1]))
      else $error("disabled counter moved");
   chk_sat_stay: assert property (
      ctr[1] == CNT_MAX && !sel_cnt |=> ctr[1] == CNT_MAX)
      else $error("saturated counter left maximum");
   chk_du_on_max: assert property (
      cnt_inc[1] && nxt[1] == CNT_MAX && !sel_cnt |=> cctl[1].du && frozen)
      else $error("maximum did not set disable_update");
   chk_page_freeze: assert property (
      frozen && !sel_cnt |=> cnt_inc == '0)
      else $error("frozen page still counting");
   chk_cmp_gate: assert property (
      cnt_inc[1] && cctl[1].etc && cctl[1].threshold_criteria == log_engine_pkg::TMC_EVERY
      |=> unit_attention_o)
      else $error("update without compare");
   chk_tmc_eq: assert property (
      cnt_inc[2] && cctl[2].etc && cctl[2].threshold_criteria == log_engine_pkg::TMC_EQ &&
      nxt[2] == thr[2] |=> unit_attention_o)
      else $error("equal threshold missed");
   chk_ua_hold: assert property (
      |cmp_hit ##1 !ua_clr [*3] |-> unit_attention_o)
      else $error("unit attention lost");
   chk_lp_reject: assert property (
      cmd_go && cmd.select && on_cnt && hdr.ctrl.lp |=>
      cmd_done_o && cmd_status_o == log_engine_pkg::ST_BAD_FIELD)
      else $error("wrong format flag accepted");
   chk_len_reject: assert property (
      cmd_go && cmd.select && on_cnt && hdr.len < log_engine_pkg::CNT_BYTES
      |=> cmd_status_o == log_engine_pkg::ST_BAD_FIELD)
      else $error("truncating length accepted");
   chk_list_wrap: assert property (
      list_take && list_next == 2'(N_LIST - 1) |=> list_next == '0 &&
      list_wrapped)
      else $error("list codes did not wrap");
   chk_save_ds: assert property (
      save_go && cctl[3].ds && !(tick && !cctl[3].target_save_disable) |=> $stable(saved[3]))
      else $error("disable_save parameter saved");
   chk_read_slot: assert property (
      !rd_i |=> rdata_o == 32'h0000_0000)
      else $error("read data outside its slot");

   cov_saturate: cover property (hit_max);
   cov_threshold: cover property (|cmp_hit ##1 unit_attention_o);
   cov_list_wrap: cover property (list_take && list_next == 2'(N_LIST - 1));
   cov_save: cover property (save_go ##1 cmd_done_o);
endmodule : log_engine

// ==== log_engine_pkg.sv ====
package log_engine_pkg;
   // sizes
   localparam int ADDR_W = 8;
   localparam int N_CNT  = 4;
   localparam int CIDX_W = 2;
   localparam int N_LIST = 4;
   localparam int LIDX_W = 2;
   localparam int CNT_W  = 16;
   localparam logic [7:0]       CNT_BYTES   = 8'h02;
   localparam logic [7:0]       LIST_BYTES  = 8'h04;
   localparam logic [CNT_W-1:0] CNT_MAX_DEF = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_ONE     = 16'h0001;

   // register offsets
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CMD    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_HDR    = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_VALUE  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_S_HDR  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_S_VAL  = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_KIND   = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_SAVED  = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_LIST   = 8'h40;

   // status and config register fields
   localparam int ST_UA_BIT     = 8;
   localparam int ST_FROZEN_BIT = 9;
   localparam int ST_WRAP_BIT   = 10;
   localparam int CFG_RLE_BIT   = 0;

   // log page codes
   localparam logic [5:0] PG_WRITE   = 6'h02;
   localparam logic [5:0] PG_READ    = 6'h03;
   localparam logic [5:0] PG_RREV    = 6'h04;
   localparam logic [5:0] PG_VERIFY  = 6'h05;
   localparam logic [5:0] PG_NONMED  = 6'h06;
   localparam logic [5:0] PG_LASTEV  = 6'h07;
   localparam logic [5:0] PG_RSV_LO  = 6'h08;
   localparam logic [5:0] PG_RSV_HI  = 6'h2F;
   localparam logic [5:0] PG_VEND_LO = 6'h30;
   localparam logic [5:0] PG_VEND_HI = 6'h3E;
   localparam logic [5:0] CNT_PAGE   = PG_NONMED;
   localparam logic [5:0] LIST_PAGE  = PG_LASTEV;

   // comparison criteria, page control bit and printable text range
   localparam logic [1:0] TMC_EVERY = 2'h0;
   localparam logic [1:0] TMC_EQ    = 2'h1;
   localparam logic [1:0] TMC_NE    = 2'h2;
   localparam logic [1:0] TMC_GT    = 2'h3;
   localparam int PC_CUM_BIT = 0;
   localparam logic [7:0] ASCII_LO = 8'h20;
   localparam logic [7:0] ASCII_HI = 8'h7E;

   // implicit save period
   localparam int AUTOSAVE_US  = 1000;
   localparam int CLK_MHZ      = 200;
   localparam int AUTOSAVE_CYC = AUTOSAVE_US * CLK_MHZ;

   localparam logic [31:0] CONFIG_RST = 32'h0000_0000;

   typedef enum logic [2:0] {
      ST_GOOD, ST_BAD_FIELD, ST_CTR_MAX, ST_LIST_EXH, ST_BAD_PAGE
   } cmd_status_t;

   typedef enum logic [3:0] {
      PK_SUPPORTED, PK_WRITE, PK_READ, PK_RREV, PK_VERIFY, PK_NONMED,
      PK_LASTEV, PK_VENDOR, PK_RESERVED, PK_OTHER
   } page_kind_t;

   typedef struct packed {
      logic       du;
      logic       ds;
      logic       target_save_disable;
      logic       etc;
      logic [1:0] threshold_criteria;
      logic       rsvd;
      logic       lp;
   } ctrl_byte_t;

   typedef struct packed {
      logic [15:0] code;
      ctrl_byte_t  ctrl;
      logic [7:0]  len;
   } param_hdr_t;

   typedef struct packed {
      logic [15:0] rsvd_hi;
      logic [1:0]  rsvd_pg;
      logic [5:0]  page_code;
      logic [3:0]  rsvd_lo;
      logic [1:0]  page_control;
      logic        save_parameters;
      logic        select;
   } cmd_word_t;
endpackage : log_engine_pkg

// ==== scsi_log_parameter_engine_test.sv ====
`timescale 1ns/10ps
module scsi_log_parameter_engine_test;
   logic                        ref_clk_i;
   logic                        arst_n_i;
   logic [7:0]                  addr;
   logic [31:0]                 wdata;
   logic [31:0]                 rdata;
   logic [31:0]                 rv;
   logic                        wr;
   logic                        rd;
   logic [3:0]                  cnt_ev;
   logic                        list_ev;
   logic [31:0]                 list_text;
   logic                        done;
   log_engine_pkg::cmd_status_t st;
   logic                        ua;
   int                          bad_count;
   int                          n_tests;
   log_engine #(.CNT_MAX(16'h0005), .AUTOSAVE_CYCLES(16)) log_engine_i (
      .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .cnt_event_i(cnt_ev), .list_event_i(list_ev),
      .list_text_i(list_text), .cmd_done_o(done),
      .cmd_status_o(st), .unit_attention_o(ua));
   initiator_model initiator_model_i (
      .ref_clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr),
      .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   task automatic chk(input string nm, input logic [31:0] g, e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      initiator_model_i.rd(a, rv);
      chk("rdata", rv, e);
   endtask : rdc
   task automatic cmd(input logic [31:0] h, v, c, input logic [2:0] s);
      initiator_model_i.wr(8'h08, h);
      initiator_model_i.wr(8'h0C, v);
      initiator_model_i.wr(8'h04, c);
      #1;
      chk("done", {31'h0, done}, 32'h1);
      chk("status", {29'h0, st}, {29'h0, s});
   endtask : cmd
   task automatic ev(input logic [3:0] m);
      @(posedge ref_clk_i);
      cnt_ev <= m;
      @(posedge ref_clk_i);
      cnt_ev <= 4'h0;
      @(posedge ref_clk_i);
      #1;
   endtask : ev
   task automatic lev(input logic [31:0] t);
      @(posedge ref_clk_i);
      list_text <= t;
      list_ev <= 1'b1;
      @(posedge ref_clk_i);
      list_ev <= 1'b0;
   endtask : lev
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   initial begin
      #200000;
      bad_count++;
      final_report();
   end
   initial begin
      {bad_count, n_tests} = 0;
      {cnt_ev, list_ev, list_text} = 0;
      arst_n_i = 1'b0;
      repeat (2) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      rdc(8'h10, 32'h0);
      rdc(8'h3C, 32'h0);
      cmd(32'h0000_0002, 32'h0, 32'h0205, 3'h4);
      rdc(8'h1C, 32'h1);
      cmd(32'h0000_0002, 32'h0, 32'h3005, 3'h4);
      rdc(8'h1C, 32'h7);
      cmd(32'h0003_0102, 32'h0, 32'h0605, 3'h1);
      cmd(32'h0003_0001, 32'h0, 32'h0605, 3'h1);
      cmd(32'h0003_0002, 32'h6, 32'h0605, 3'h1);
      cmd(32'h0001_9002, 32'h3, 32'h0605, 3'h0);
      ev(4'h2);
      chk("ua", {31'h0, ua}, 32'h1);
      initiator_model_i.wr(8'h10, 32'h100);
      cmd(32'h0002_1402, 32'h2, 32'h0601, 3'h0);
      cmd(32'h0002_1402, 32'h0, 32'h0605, 3'h0);
      ev(4'h4);
      chk("ua", {31'h0, ua}, 32'h0);
      ev(4'h4);
      chk("ua", {31'h0, ua}, 32'h1);
      cmd(32'h0001_0002, 32'h0, 32'h0604, 3'h0);
      rdc(8'h18, 32'h4);
      initiator_model_i.wr(8'h00, 32'h1);
      ev(4'h2);
      ev(4'h3);
      cmd(32'h0001_0002, 32'h0, 32'h0606, 3'h2);
      rdc(8'h18, 32'h5);
      rdc(8'h24, 32'h5);
      initiator_model_i.rd(8'h14, rv);
      chk("du", {31'h0, rv[15]}, 32'h1);
      cmd(32'h0000_0002, 32'h0, 32'h0604, 3'h2);
      rdc(8'h18, 32'h0);
      cmd(32'h0003_6002, 32'h2, 32'h0607, 3'h2);
      ev(4'h9);
      cmd(32'h0003_0002, 32'h0, 32'h0606, 3'h0);
      rdc(8'h18, 32'h3);
      ev(4'h1);
      repeat (20) @(posedge ref_clk_i);
      rdc(8'h20, 32'h2);
      rdc(8'h2C, 32'h0);
      lev(32'h4142_431F);
      rdc(8'h40, 32'h0);
      for (int j = 0; j < 5; j++) lev(32'h4142_4340 + j);
      rdc(8'h40, 32'h4142_4344);
      rdc(8'h44, 32'h4142_4341);
      cmd(32'h0000_0104, 32'h0, 32'h0704, 3'h3);
      final_report();
   end
endmodule : scsi_log_parameter_engine_test
